/* File: iop_emcy_tx.sv */
`timescale 1ns/1ps
module iop_emcy_tx
    import iop_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [63:0] msg,
    input wire logic mbx_ready,
    output logic busy,
    output logic mbx_valid,
    output logic [7:0] mbx_data,
    output logic mbx_last
);

    iop_tx_state_t state;
    logic [63:0] shreg;
    logic [2:0] count;

    ////////////////////////////////////////////////////////////////////////
    // Eight bytes leave low byte first; the mailbox may stall any byte.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= TX_IDLE;
            shreg <= 64'h0;
            count <= 3'h0;
        end else begin
            case (state)
                TX_IDLE: begin
                    if (start) begin
                        shreg <= msg;
                        count <= 3'h0;
                        state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (mbx_ready) begin
                        shreg <= shreg >> 8;
                        count <= count + 3'h1;
                        if (count == 3'h7) begin
                            state <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    state <= TX_IDLE;
                end
            endcase
        end
    end

    assign busy = (state == TX_SEND);
    assign mbx_valid = busy;
    assign mbx_data = shreg[7:0];
    assign mbx_last = busy && (count == 3'h7);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_taken;
        start && (state == TX_IDLE);
    endsequence

    a_first_byte_low: assert property (s_taken |=> mbx_data == $past(msg[7:0]))
        else $error("first mailbox byte is not the low byte");
    a_frame_eight_bytes: assert property (s_taken ##1 mbx_ready [*8] |=> !busy)
        else $error("emergency frame is not eight bytes");
    a_frame_not_short: assert property (s_taken ##1 mbx_ready [*7] |=> mbx_last)
        else $error("last byte flag not on eighth byte");

endmodule : iop_emcy_tx

/* File: iop_io_image.sv */
`timescale 1ns/1ps
// Contract
// - Input lines one to eight appear in input image byte 0, bits 0 to 7.
// - Output lines one to four follow output image bits 0 to 3; bits 4 to 7 ignored.
// - Status word bits 0-5 report output, actuator and sensor supply faults; rest zero.
// - An emergency message is eight bytes: code, error register, five diagnostic bytes.
// - Emergency messages go out unasked over the mailbox, with no confirmation awaited.
// - Supply faults use codes 3001-3005 with register bit 2; overtemperature 4001, bit 4.
// - A message is sent both when a fault appears and when it goes away.
// - A cleared fault sends code 0000, its register bit clear, same diagnostic data.
// - The master picks sync-manager mode or distributed-clock mode for the update.
// - Sync-manager mode free-runs the I/O every cycle and is the reset default.
// - In distributed-clock mode outputs apply a fixed delay after each sync pulse.
// - In distributed-clock mode inputs are sampled a fixed delay after each sync pulse.
// - Writing one to the restore register requests factory defaults at next power-on.
// - On a communication timeout all outputs take their configured safe values.
// - After boot the ready light is green, steady or flashing by bus status.
// - Multi-byte items travel least significant byte first.
module iop_io_image
    import iop_pkg::*;
#(
    parameter int WD_CYCLES = WD_TIMEOUT_CYC,
    parameter int FLASH_CYCLES = FLASH_HALF_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] digital_input_line,
    input wire logic [5:0] io_fault_line,
    input wire logic [5:0] supply_fault_line,
    input wire logic sync0_line,
    input wire logic boot_done,
    input wire logic mbx_ready,
    output logic [3:0] digital_output_line,
    output logic mbx_valid,
    output logic [7:0] mbx_data,
    output logic mbx_last,
    output logic ready_led_green,
    output logic factory_restore_req,
    output logic irq
);

    localparam int PIN_W = 21;
    localparam int A_OUT_DLY = OUT_DELAY_CYC;
    localparam int A_IN_REST = int'(IN_DELAY_CYC) - 1;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] din,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic [2:0] lowest_set(input logic [5:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = EMCY_FAULTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : lowest_set

    function automatic logic [63:0] emcy_message(input logic [2:0] idx, input logic active,
                                                 input logic [5:0] rep);
        logic [15:0] code;
        logic [7:0] errreg;
        logic [7:0] diag;
        errreg = 8'h00;
        errreg[ERRREG_SUPPLY_BIT] = |rep[4:0];
        errreg[ERRREG_TEMP_BIT] = rep[EMCY_TEMP_IDX];
        diag = DIAG_ID_BASE + 8'(idx);
        if (idx == 3'(EMCY_TEMP_IDX)) begin
            code = EMCY_CODE_TEMP;
            errreg[ERRREG_TEMP_BIT] = active;
        end else begin
            code = EMCY_CODE_SUPPLY_BASE + 16'(idx);
            errreg[ERRREG_SUPPLY_BIT] = active;
        end
        if (!active) begin
            code = EMCY_CODE_RESET;
        end
        return {24'h00_0000, diag, 8'h00, errreg, code};
    endfunction : emcy_message

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: a level is taken once stages two and three agree.
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;
    logic [PIN_W-1:0] pin_clean;
    wire [PIN_W-1:0] pin_raw = {sync0_line, supply_fault_line, io_fault_line, digital_input_line};
    wire [PIN_W-1:0] next_clean = (pin_s2 & pin_s3) | (pin_clean & (pin_s2 | pin_s3));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_clean <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_clean <= next_clean;
        end
    end

    wire [7:0] di_clean = pin_clean[7:0];
    wire [5:0] io_clean = pin_clean[13:8];
    wire [5:0] emcy_clean = pin_clean[19:14];
    wire sync0_clean = pin_clean[20];

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode. Every access is acked one cycle later.
    logic [7:0] out_image;
    logic [31:0] control;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [7:0] in_image;
    logic [31:0] io_status;

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire bus_rd = bus_req && !wb_we_i;
    wire sel_out = (wb_adr_i == OFF_OUTPUT_IMAGE);
    wire sel_ctl = (wb_adr_i == OFF_CONTROL);
    wire sel_rst = (wb_adr_i == OFF_RESTORE);
    wire sel_irqs = (wb_adr_i == OFF_IRQ_STATUS);
    wire sel_irqm = (wb_adr_i == OFF_IRQ_MASK);
    wire out_write = bus_wr && sel_out && wb_sel_i[0];
    wire dc_mode = control[CTL_DC_MODE];
    wire [3:0] safe_value = control[CTL_SAFE_LSB +: 4];
    wire [31:0] rd_data =
        (wb_adr_i == OFF_INPUT_IMAGE) ? {24'h00_0000, in_image} :
        sel_out ? {24'h00_0000, out_image} :
        (wb_adr_i == OFF_IO_STATUS) ? io_status :
        sel_ctl ? control :
        sel_rst ? {31'h0, factory_restore_req} :
        sel_irqs ? {29'h0, irq_status} :
        sel_irqm ? {29'h0, irq_mask} : 32'h0000_0000;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            out_image <= 8'h00;
            control <= CONTROL_RESET;
            irq_mask <= '0;
            factory_restore_req <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? rd_data : 32'h0000_0000;
            if (out_write) begin
                out_image <= wb_dat_i[7:0];
            end
            if (bus_wr && sel_ctl) begin
                control <= merge_bytes(control, wb_dat_i, wb_sel_i);
            end
            if (bus_wr && sel_irqm && wb_sel_i[0]) begin
                irq_mask <= wb_dat_i[IRQ_BITS-1:0];
            end
            if (bus_wr && sel_rst && (merge_bytes(32'h0, wb_dat_i, wb_sel_i) == RESTORE_KEY)) begin
                factory_restore_req <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Distributed-clock timers. A sync pulse during a running delay is
    // ignored, so the sync period must exceed the longer delay.
    logic [7:0] out_cnt;
    logic [7:0] in_cnt;
    logic out_armed;
    logic in_armed;
    logic sync0_prev;
    wire sync0_rise = sync0_clean && !sync0_prev;
    wire out_fire = out_armed && (out_cnt == 8'h01);
    wire in_fire = in_armed && (in_cnt == 8'h01);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync0_prev <= 1'b0;
            out_cnt <= 8'h00;
            in_cnt <= 8'h00;
            out_armed <= 1'b0;
            in_armed <= 1'b0;
        end else begin
            sync0_prev <= sync0_clean;
            if (dc_mode && sync0_rise && !out_armed) begin
                out_cnt <= OUT_DELAY_CYC;
                out_armed <= 1'b1;
            end else if (out_armed) begin
                out_cnt <= out_cnt - 8'h01;
                out_armed <= !out_fire;
            end
            if (dc_mode && sync0_rise && !in_armed) begin
                in_cnt <= IN_DELAY_CYC;
                in_armed <= 1'b1;
            end else if (in_armed) begin
                in_cnt <= in_cnt - 8'h01;
                in_armed <= !in_fire;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Process image, watchdog and outputs.
    logic [3:0] dout_applied;
    logic [31:0] wd_cnt;
    logic wd_expired;
    wire wd_hit = control[CTL_WD_ENABLE] && !out_write && !wd_expired && (wd_cnt == 32'(WD_CYCLES - 1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            in_image <= 8'h00;
            io_status <= 32'h0000_0000;
            dout_applied <= 4'h0;
            digital_output_line <= 4'h0;
            wd_cnt <= 32'h0000_0000;
            wd_expired <= 1'b0;
        end else begin
            if (!dc_mode || in_fire) begin
                in_image <= di_clean;
            end
            io_status <= {26'h000_0000, io_clean};
            if (!dc_mode || out_fire) begin
                dout_applied <= out_image[3:0];
            end
            digital_output_line <= wd_expired ? safe_value : dout_applied;
            if (out_write || !control[CTL_WD_ENABLE]) begin
                wd_cnt <= 32'h0000_0000;
                wd_expired <= 1'b0;
            end else if (wd_hit) begin
                wd_expired <= 1'b1;
            end else if (!wd_expired) begin
                wd_cnt <= wd_cnt + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Emergency reporting. A fault whose level differs from the last
    // reported level is pending; the lowest pending one is sent first.
    logic [5:0] emcy_reported;
    logic tx_busy;
    wire [5:0] pending = emcy_clean ^ emcy_reported;
    wire tx_start = (|pending) && !tx_busy;
    wire [2:0] tx_idx = lowest_set(pending);
    wire [5:0] next_reported = emcy_reported ^ (6'h01 << tx_idx);
    wire [63:0] tx_msg = emcy_message(tx_idx, emcy_clean[tx_idx], next_reported);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            emcy_reported <= 6'h00;
        end else if (tx_start) begin
            emcy_reported <= next_reported;
        end
    end

    iop_emcy_tx u_emcy_tx (
        .clock(clock),
        .reset_n(reset_n),
        .start(tx_start),
        .msg(tx_msg),
        .mbx_ready(mbx_ready),
        .busy(tx_busy),
        .mbx_valid(mbx_valid),
        .mbx_data(mbx_data),
        .mbx_last(mbx_last)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: a new event wins over the clearing read.
    logic [IRQ_BITS-1:0] irq_events;
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_EMCY_SENT] = mbx_valid && mbx_ready && mbx_last;
        irq_events[IRQ_WD_TIMEOUT] = wd_hit;
        irq_events[IRQ_IO_CHANGE] = (io_status[5:0] != io_clean);
    end
    wire [IRQ_BITS-1:0] irq_clear = (bus_rd && sel_irqs) ? '1 : '0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready light. The flash rate is a one-cycle enable from a divider.
    logic [31:0] flash_cnt;
    logic flash_phase;
    logic boot_seen;
    wire flash_tick = (flash_cnt == 32'(FLASH_CYCLES - 1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flash_cnt <= 32'h0000_0000;
            flash_phase <= 1'b0;
            boot_seen <= 1'b0;
            ready_led_green <= 1'b0;
        end else begin
            flash_cnt <= flash_tick ? 32'h0000_0000 : flash_cnt + 32'h0000_0001;
            if (flash_tick) begin
                flash_phase <= !flash_phase;
            end
            boot_seen <= boot_seen || boot_done;
            ready_led_green <= boot_seen && (control[CTL_BUS_RUN] || flash_phase);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_out_sync;
        dc_mode && sync0_rise && !out_armed;
    endsequence
    sequence s_in_sync;
        dc_mode && sync0_rise && !in_armed;
    endsequence

    a_sm_default_mode: assert property ($rose(reset_n) |-> !dc_mode)
        else $error("distributed-clock mode active after reset");
    a_input_image_map: assert property (!dc_mode && $past(!dc_mode) |-> in_image == $past(di_clean))
        else $error("input image does not follow input lines");
    a_output_image_map: assert property ((!dc_mode && !wd_expired) [*2] |=>
        digital_output_line == $past(out_image[3:0], 2))
        else $error("outputs do not follow output image");
    a_status_track: assert property (io_status[31:6] == 26'h0 && io_status[5:0] == $past(io_clean))
        else $error("status word does not track fault lines");
    a_dc_output_delay: assert property (s_out_sync |-> ##A_OUT_DLY out_fire)
        else $error("output delay after sync pulse is wrong");
    a_dc_input_delay: assert property (s_in_sync |-> !in_fire [*2] ##A_IN_REST in_fire)
        else $error("input delay after sync pulse is wrong");
    a_emcy_on_change: assert property (emcy_clean != $past(emcy_clean) |-> ##[0:400] tx_start)
        else $error("fault change sent no emergency message");
    a_clear_code: assert property (tx_start && !emcy_clean[tx_idx] |->
        tx_msg[15:0] == EMCY_CODE_RESET && tx_msg[39:32] == DIAG_ID_BASE + 8'(tx_idx))
        else $error("clearing message has wrong code or diagnostic byte");
    a_temp_code: assert property (tx_start && tx_idx == 3'h5 && emcy_clean[5] |->
        tx_msg[15:0] == 16'h4001 && tx_msg[20])
        else $error("overtemperature message content wrong");
    a_safe_state: assert property (wd_expired |=> digital_output_line == $past(safe_value))
        else $error("outputs not in safe state after timeout");
    a_restore_req: assert property (bus_wr && sel_rst && wb_sel_i == 4'hF && wb_dat_i == 32'h1 |=>
        factory_restore_req [*3])
        else $error("restore request not latched");
    a_led_steady: assert property (boot_seen && control[CTL_BUS_RUN] |=> ready_led_green)
        else $error("ready light not steady green");

endmodule : iop_io_image

/* File: iop_io_image_test.sv */
`timescale 1ns/1ps
module iop_io_image_test;
    import iop_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sync0 = 1'b0, boot = 1'b0, slow = 1'b0;
    logic [7:0] adr = 8'h00, din = 8'h00, mdata;
    logic [3:0] sel = 4'hF, dout;
    logic [31:0] wdat = 32'h0000_0000, rdat, rd;
    logic [5:0] iof = 6'h00, sup = 6'h00;
    logic ack, mready, mvalid, mlast, led, rreq, irq, got;
    logic [63:0] msg;
    int n_errors = 0;
    int n_tests = 0;
    always #12.5 clock = ~clock;
    iop_io_image #(.WD_CYCLES(50), .FLASH_CYCLES(8)) i_iop_io_image (.clock(clock), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .digital_input_line(din), .io_fault_line(iof),
        .supply_fault_line(sup), .sync0_line(sync0), .boot_done(boot), .mbx_ready(mready),
        .digital_output_line(dout), .mbx_valid(mvalid), .mbx_data(mdata), .mbx_last(mlast),
        .ready_led_green(led), .factory_restore_req(rreq), .irq(irq));
    iop_mbx_sink i_iop_mbx_sink (.clock(clock), .reset_n(reset_n), .slow(slow), .mbx_valid(mvalid),
        .mbx_data(mdata), .mbx_last(mlast), .mbx_ready(mready), .msg(msg), .got(got));
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Called just after an edge; the request stands until ack is seen high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask : wb
    ////////////////////////////////////////////////////////////////
    task automatic t_basic();
        wb(1'b0, OFF_CONTROL, 32'h0000_0000);
        chk("control", rd, 32'h0000_0000);
        wb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        chk("led", led, 1'b0);
        din <= 8'hB1;
        iof <= 6'h2A;
        wb(1'b1, OFF_OUTPUT_IMAGE, 32'h0000_00F6);
        repeat (6) @(posedge clock);
        chk("outputs", dout, 4'h6);
        wb(1'b0, OFF_INPUT_IMAGE, 32'h0000_0000);
        chk("in image", rd, 32'h0000_00B1);
        wb(1'b0, OFF_IO_STATUS, 32'h0000_0000);
        chk("io status", rd, 32'h0000_002A);
        iof <= 6'h00;
        repeat (6) @(posedge clock);
        wb(1'b0, OFF_IO_STATUS, 32'h0000_0000);
        chk("io status", rd, 32'h0000_0000);
        $display("test basic done");
    endtask : t_basic
    task automatic t_emcy();
        logic [15:0] code;
        logic [7:0] er;
        int k;
        wb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            slow <= i[0];
            for (int c = 0; c < 2; c++) begin
                sup <= (c == 1) ? 6'h00 : 6'(1 << i);
                k = 0;
                do begin
                    @(posedge clock);
                    k++;
                end while (got !== 1'b1 && k < 200);
                code = (c == 1) ? 16'h0000 : ((i == 5) ? 16'h4001 : 16'h3001 + 16'(i));
                er = (c == 1) ? 8'h00 : ((i == 5) ? 8'h10 : 8'h04);
                chk("emcy", msg, {24'h00_0000, 8'(i + 1), 8'h00, er, code});
                chk("emcy count", k < 200, 1'b1);
            end
        end
        repeat (3) @(posedge clock);
        chk("irq", irq, 1'b1);
        wb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
        chk("irq status", rd[0], 1'b1);
        repeat (3) @(posedge clock);
        chk("irq", irq, 1'b0);
        $display("test emcy done");
    endtask : t_emcy
    task automatic t_dc();
        wb(1'b1, OFF_CONTROL, 32'h0000_0001);
        din <= 8'h3C;
        wb(1'b1, OFF_OUTPUT_IMAGE, 32'h0000_0009);
        repeat (10) @(posedge clock);
        wb(1'b0, OFF_INPUT_IMAGE, 32'h0000_0000);
        chk("dc in", rd, 32'h0000_00B1);
        chk("dc out", dout, 4'h6);
        sync0 <= 1'b1;
        repeat (4) @(posedge clock);
        sync0 <= 1'b0;
        repeat (22) @(posedge clock);
        wb(1'b0, OFF_INPUT_IMAGE, 32'h0000_0000);
        chk("dc in", rd, 32'h0000_003C);
        chk("dc out", dout, 4'h6);
        repeat (20) @(posedge clock);
        chk("dc out", dout, 4'h9);
        $display("test dc done");
    endtask : t_dc
    task automatic t_wd();
        wb(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
        wb(1'b1, OFF_CONTROL, 32'h0000_0A02);
        wb(1'b1, OFF_OUTPUT_IMAGE, 32'h0000_0005);
        repeat (10) @(posedge clock);
        chk("wd out", dout, 4'h5);
        wb(1'b0, OFF_CONTROL, 32'h0000_0000);
        chk("control rd", rd, 32'h0000_0A02);
        repeat (60) @(posedge clock);
        chk("safe out", dout, 4'hA);
        chk("wd irq line", irq, 1'b1);
        wb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
        chk("wd irq", rd[1], 1'b1);
        wb(1'b1, OFF_OUTPUT_IMAGE, 32'h0000_0005);
        repeat (4) @(posedge clock);
        chk("wd out", dout, 4'h5);
        wb(1'b1, OFF_RESTORE, 32'h0000_0002);
        chk("restore", rreq, 1'b0);
        wb(1'b1, OFF_RESTORE, 32'h0000_0001);
        chk("restore", rreq, 1'b1);
        wb(1'b0, OFF_RESTORE, 32'h0000_0000);
        chk("restore rd", rd, 32'h0000_0001);
        $display("test watchdog done");
    endtask : t_wd
    task automatic t_led();
        int ones;
        ones = 0;
        boot <= 1'b1;
        wb(1'b1, OFF_CONTROL, 32'h0000_0004);
        repeat (12) @(posedge clock);
        chk("led steady", led, 1'b1);
        wb(1'b1, OFF_CONTROL, 32'h0000_0000);
        repeat (32) begin
            @(posedge clock);
            if (led === 1'b1) ones++;
        end
        chk("led flash", ones > 4 && ones < 28, 1'b1);
        $display("test led done");
    endtask : t_led
    ////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_basic();
        t_emcy();
        t_dc();
        t_wd();
        t_led();
        end_of_test();
    end
endmodule : iop_io_image_test

/* File: iop_mbx_sink.sv */
`timescale 1ns/1ps
module iop_mbx_sink (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic mbx_valid,
    input wire logic [7:0] mbx_data,
    input wire logic mbx_last,
    output logic mbx_ready,
    output logic [63:0] msg,
    output logic got
);
    // Nothing is ever answered back, since emergency messages carry no confirmation.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mbx_ready <= 1'b0;
            msg <= 64'h0000_0000_0000_0000;
            got <= 1'b0;
        end else begin
            mbx_ready <= slow ? ~mbx_ready : 1'b1;
            got <= mbx_valid && mbx_ready && mbx_last;
            if (mbx_valid && mbx_ready) begin
                msg <= {mbx_data, msg[63:8]};
            end
        end
    end
endmodule : iop_mbx_sink

/* File: iop_pkg.sv */
package iop_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing.
    localparam int CLOCK_MHZ = 40;
    localparam int OUTPUT_DELAY_NS = 1000;
    localparam int INPUT_DELAY_NS = 500;
    localparam logic [7:0] OUT_DELAY_CYC = 8'((OUTPUT_DELAY_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [7:0] IN_DELAY_CYC = 8'((INPUT_DELAY_NS * CLOCK_MHZ + 999) / 1000);
    localparam int WD_TIMEOUT_MS = 100;
    localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLOCK_MHZ * 1000;
    localparam int FLASH_HALF_MS = 500;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLOCK_MHZ * 1000;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] OFF_INPUT_IMAGE = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_IMAGE = 8'h04;
    localparam logic [7:0] OFF_IO_STATUS = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0C;
    localparam logic [7:0] OFF_RESTORE = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    // Control fields.
    localparam int CTL_DC_MODE = 0;
    localparam int CTL_WD_ENABLE = 1;
    localparam int CTL_BUS_RUN = 2;
    localparam int CTL_SAFE_LSB = 8;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] RESTORE_KEY = 32'h0000_0001;

    // Interrupt status bits.
    localparam int IRQ_EMCY_SENT = 0;
    localparam int IRQ_WD_TIMEOUT = 1;
    localparam int IRQ_IO_CHANGE = 2;
    localparam int IRQ_BITS = 3;

    ////////////////////////////////////////////////////////////////////////
    // Emergency message content.
    localparam int EMCY_FAULTS = 6;
    localparam int EMCY_TEMP_IDX = 5;
    localparam logic [15:0] EMCY_CODE_SUPPLY_BASE = 16'h3001;
    localparam logic [15:0] EMCY_CODE_TEMP = 16'h4001;
    localparam logic [15:0] EMCY_CODE_RESET = 16'h0000;
    localparam int ERRREG_SUPPLY_BIT = 2;
    localparam int ERRREG_TEMP_BIT = 4;
    localparam logic [7:0] DIAG_ID_BASE = 8'h01;

    typedef enum {TX_IDLE, TX_SEND} iop_tx_state_t;

endpackage : iop_pkg
